/* File: rtl/hpi_chan_regs.sv */
// Purpose: register file of one channel seen through the host port
// Assumes: write strobe is one cycle per access
// Notes:   status register is computed, not stored
`timescale 1ns/1ps
module hpi_chan_regs #(
   parameter int NUM_SRC = 4
) (
   input  wire logic               clk_i,
   input  wire logic               resetn_i,
   input  wire logic               wr_i,
   input  wire logic [2:0]         sel_i,
   input  wire logic [7:0]         wdata_i,
   input  wire logic [NUM_SRC-1:0] src_i,
   output logic      [7:0]         rdata_o,
   output logic                    irq_o
);
   logic [7:0] regs      [hpi_pkg::NUM_REGS];
   logic [7:0] next_regs [hpi_pkg::NUM_REGS];
   logic [NUM_SRC-1:0] enabled;

   // capture the bus into the addressed register
   always_comb begin
      for (int i = 0; i < hpi_pkg::NUM_REGS; i++) begin
         next_regs[i] = regs[i];
      end
      if (wr_i) begin
         next_regs[sel_i] = wdata_i;
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         for (int i = 0; i < hpi_pkg::NUM_REGS; i++) begin
            regs[i] <= hpi_pkg::REG_RESET;
         end
      end else begin
         regs <= next_regs;
      end
   end

   // the addressed register holds the bus value one edge after the strobe
   chk_write_lands: assert property (
      @(posedge clk_i) disable iff (!resetn_i)
      wr_i |=> (regs[$past(sel_i)] == $past(wdata_i)))
      else $error("write did not land in the addressed register");

   // a source only counts when its enable bit is set
   assign enabled = src_i & regs[hpi_pkg::IDX_INT_ENABLE][NUM_SRC-1:0];
   assign irq_o   = |enabled;

   // status reads back pending state, other indices read stored value
   always_comb begin
      if (sel_i == hpi_pkg::IDX_INT_STATUS) begin
         rdata_o = irq_o ? hpi_pkg::STATUS_PEND : hpi_pkg::STATUS_NONE;
      end else begin
         rdata_o = regs[sel_i];
      end
   end
endmodule // hpi_chan_regs

/* File: rtl/hpi_host_port.sv */
// Purpose: parallel host port with read/write direction and shared interrupt
// Assumes: host holds address and data stable while chip select is low
// Notes:   one access per chip select assertion; bus pins split into i/o/oe
//          a write lands on the first edge that sees chip select low; read
//          data appears one edge after that and stands until select rises
//          the interrupt pin is open-drain style: only its enable ever moves
`timescale 1ns/1ps
module hpi_host_port #(
   parameter int NUM_SRC = 4
) (
   input  wire logic                       CLK_SYS_I,
   input  wire logic                       RESETN_I,
   input  wire logic                       CS_N_I,
   input  wire logic                       READ_I,
   input  wire logic                       CHAN_SEL_I,
   input  wire logic [2:0]                 REG_SEL_I,
   input  wire logic [7:0]                 DATA_I,
   input  wire logic [NUM_SRC-1:0]         SRC_A_I,
   input  wire logic [NUM_SRC-1:0]         SRC_B_I,
   output logic      [7:0]                 DATA_O,
   output logic                            DATA_OE_O,
   output logic                            IRQ_N_O,
   output logic                            IRQ_OE_O
);
   hpi_pkg::hpi_req_type   req;
   hpi_pkg::hpi_state_type state;
   hpi_pkg::hpi_state_type next_state;
   logic [7:0]             next_data;
   logic                   next_oe;
   logic                   next_irq_oe;
   logic [hpi_pkg::NUM_CHAN-1:0] wr;
   logic [hpi_pkg::NUM_CHAN-1:0] irq;
   logic [7:0]             rdata [hpi_pkg::NUM_CHAN];
   logic [7:0]             sel_rdata;

   assign req = '{sel_n: CS_N_I, read: READ_I, chan: CHAN_SEL_I,
                  reg_sel: REG_SEL_I, wdata: DATA_I};

   // one register file per channel, picked by the channel address bit
   genvar g;
   generate
      for (g = 0; g < hpi_pkg::NUM_CHAN; g++) begin : g_chan
         assign wr[g] = (state == hpi_pkg::ST_IDLE) && !req.sel_n && !req.read
                        && (req.chan == 1'(g));
         hpi_chan_regs #(.NUM_SRC(NUM_SRC)) u_regs (
            .clk_i    (CLK_SYS_I),
            .resetn_i (RESETN_I),
            .wr_i     (wr[g]),
            .sel_i    (req.reg_sel),
            .wdata_i  (req.wdata),
            .src_i    ((g == 0) ? SRC_A_I : SRC_B_I),
            .rdata_o  (rdata[g]),
            .irq_o    (irq[g])
         );
      end
   endgenerate

   // read mux sits ahead of the output flops so the pins stay registered
   assign sel_rdata = rdata[req.chan];

   // access sequencer: one transfer, then wait for chip select to rise
   always_comb begin
      next_state = state;
      next_data  = DATA_O;
      next_oe    = 1'b0;
      case (state)
         hpi_pkg::ST_IDLE: begin
            if (!req.sel_n) begin
               next_state = req.read ? hpi_pkg::ST_READ : hpi_pkg::ST_WRITE;
            end
         end
         hpi_pkg::ST_READ: begin
            if (req.sel_n || !req.read) begin
               next_state = hpi_pkg::ST_IDLE;
            end else begin
               next_data = sel_rdata;
               next_oe   = 1'b1;
            end
         end
         hpi_pkg::ST_WRITE: begin
            if (req.sel_n) begin
               next_state = hpi_pkg::ST_IDLE;
            end
         end
         default: next_state = hpi_pkg::ST_IDLE;
      endcase
   end

   // either channel pulls the shared line; never driven high
   assign next_irq_oe = |irq;

   always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         state     <= hpi_pkg::ST_IDLE;
         DATA_O    <= hpi_pkg::REG_RESET;
         DATA_OE_O <= 1'b0;
         IRQ_OE_O  <= 1'b0;
         IRQ_N_O   <= 1'b0;
      end else begin
         state     <= next_state;
         DATA_O    <= next_data;
         DATA_OE_O <= next_oe;
         IRQ_OE_O  <= next_irq_oe;
         IRQ_N_O   <= 1'b0;
      end
   end

   // bus is driven only while a read is in progress
   chk_bus_release: assert property (
      @(posedge CLK_SYS_I) disable iff (!RESETN_I)
      DATA_OE_O |-> !$past(CS_N_I) && $past(READ_I))
      else $error("data bus driven outside a read");

   // a request from either channel pulls the shared line one edge later
   chk_irq_merge: assert property (
      @(posedge CLK_SYS_I) disable iff (!RESETN_I)
      (irq[0] || irq[1]) |=> IRQ_OE_O)
      else $error("channel request did not pull the shared line");

   // with nothing enabled pending the line is let go
   chk_irq_clear: assert property (
      @(posedge CLK_SYS_I) disable iff (!RESETN_I)
      !(irq[0] || irq[1]) |=> !IRQ_OE_O)
      else $error("shared line pulled with nothing enabled pending");

   // the level under the enable is never a high drive
   chk_irq_low_only: assert property (
      @(posedge CLK_SYS_I) disable iff (!RESETN_I)
      IRQ_OE_O |-> !IRQ_N_O)
      else $error("shared line driven high");

   // read data is the addressed register of the addressed channel
   chk_read_data: assert property (
      @(posedge CLK_SYS_I) disable iff (!RESETN_I)
      (state == hpi_pkg::ST_READ && !CS_N_I && READ_I) |=>
      DATA_OE_O && DATA_O == $past(sel_rdata))
      else $error("read did not return the addressed register");

   // a held chip select must not repeat the write strobe
   chk_one_write: assert property (
      @(posedge CLK_SYS_I) disable iff (!RESETN_I)
      (wr != 2'b00) |=> (wr == 2'b00))
      else $error("more than one write per chip select");

   // the strobe goes to the selected channel only, and only for a write
   chk_write_sel: assert property (
      @(posedge CLK_SYS_I) disable iff (!RESETN_I)
      (wr != 2'b00) |-> !CS_N_I && !READ_I && wr[CHAN_SEL_I] && $onehot(wr))
      else $error("write strobe to wrong channel");

   // a write in progress never turns the bus around
   chk_no_oe_write: assert property (
      @(posedge CLK_SYS_I) disable iff (!RESETN_I)
      (!CS_N_I && !READ_I) ##1 (!CS_N_I && !READ_I) |-> !DATA_OE_O)
      else $error("data bus driven during a write");

   // a read request seen in idle moves to the read state
   chk_read_enter: assert property (
      @(posedge CLK_SYS_I) disable iff (!RESETN_I)
      (state == hpi_pkg::ST_IDLE && !CS_N_I && READ_I) |=> (state == hpi_pkg::ST_READ))
      else $error("read request not taken");

   // a write request seen in idle moves to the write wait state
   chk_write_enter: assert property (
      @(posedge CLK_SYS_I) disable iff (!RESETN_I)
      (state == hpi_pkg::ST_IDLE && !CS_N_I && !READ_I) |=> (state == hpi_pkg::ST_WRITE))
      else $error("write request not taken");

   // chip select high ends any access on the next edge
   chk_cs_return: assert property (
      @(posedge CLK_SYS_I) disable iff (!RESETN_I)
      (state != hpi_pkg::ST_IDLE && CS_N_I) |=> (state == hpi_pkg::ST_IDLE))
      else $error("access did not end after chip select rose");

   // no access starts without chip select
   chk_idle_hold: assert property (
      @(posedge CLK_SYS_I) disable iff (!RESETN_I)
      (state == hpi_pkg::ST_IDLE && CS_N_I) |=> (state == hpi_pkg::ST_IDLE))
      else $error("access started without chip select");

   // driven read data is dropped one edge after chip select rises
   chk_oe_drop: assert property (
      @(posedge CLK_SYS_I) disable iff (!RESETN_I)
      (DATA_OE_O && CS_N_I) |=> !DATA_OE_O)
      else $error("data bus still driven after chip select rose");

   // the bus is released whenever the port sits idle
   chk_oe_idle: assert property (
      @(posedge CLK_SYS_I) disable iff (!RESETN_I)
      (state == hpi_pkg::ST_IDLE) |-> !DATA_OE_O)
      else $error("data bus driven while idle");

   // the bus is released while a write waits for chip select to rise
   chk_oe_in_write: assert property (
      @(posedge CLK_SYS_I) disable iff (!RESETN_I)
      (state == hpi_pkg::ST_WRITE) |-> !DATA_OE_O)
      else $error("data bus driven in the write wait state");

   // the bus turns around only out of the read state
   chk_oe_source: assert property (
      @(posedge CLK_SYS_I) disable iff (!RESETN_I)
      $rose(DATA_OE_O) |-> ($past(state) == hpi_pkg::ST_READ))
      else $error("data bus enabled outside the read state");

   // read data keeps standing while the host holds the read
   chk_read_hold: assert property (
      @(posedge CLK_SYS_I) disable iff (!RESETN_I)
      (DATA_OE_O && state == hpi_pkg::ST_READ && !CS_N_I && READ_I) |=> DATA_OE_O)
      else $error("read data dropped while the read was held");

   // strobes only come out of idle
   chk_no_wr_busy: assert property (
      @(posedge CLK_SYS_I) disable iff (!RESETN_I)
      (state != hpi_pkg::ST_IDLE) |-> (wr == '0))
      else $error("write strobe outside idle");

   // no strobe without chip select
   chk_wr_needs_cs: assert property (
      @(posedge CLK_SYS_I) disable iff (!RESETN_I)
      CS_N_I |-> (wr == '0))
      else $error("write strobe without chip select");

   // both channels asking at once still pull the one line
   chk_irq_both: assert property (
      @(posedge CLK_SYS_I) disable iff (!RESETN_I)
      (irq[0] && irq[1]) |=> IRQ_OE_O)
      else $error("joint request did not pull the shared line");

   // the line is let go only once every channel is quiet
   chk_irq_release: assert property (
      @(posedge CLK_SYS_I) disable iff (!RESETN_I)
      $fell(IRQ_OE_O) |-> !$past(irq[0]) && !$past(irq[1]))
      else $error("shared line released with a request pending");

   // the line is pulled only for an enabled pending source
   chk_irq_rise: assert property (
      @(posedge CLK_SYS_I) disable iff (!RESETN_I)
      $rose(IRQ_OE_O) |-> ($past(irq[0]) || $past(irq[1])))
      else $error("shared line pulled with no request");

   // a corrupted state code falls to the default branch, which releases the bus and returns to idle
   chk_state_legal: assert property (
      @(posedge CLK_SYS_I) disable iff (!RESETN_I)
      $onehot(state))
      else $error("access sequencer state is not one-hot");
endmodule // hpi_host_port

/* File: rtl/hpi_pkg.sv */
// Purpose: shared constants and carrier types for the host port block
// Assumes: one clock, asynchronous active-low reset, synchronous pin inputs
// Notes:   the register contents below stand in for the channel logic
package hpi_pkg;
   localparam int   DATA_W     = 8;
   localparam int   REG_SEL_W  = 3;
   localparam int   NUM_CHAN   = 2;
   localparam int   NUM_REGS   = 8;
   localparam logic [7:0] REG_RESET = 8'h00;
   // register index holding interrupt enables, and the one showing status
   localparam logic [2:0] IDX_INT_ENABLE = 3'h1;
   localparam logic [2:0] IDX_INT_STATUS = 3'h2;
   localparam logic [7:0] STATUS_NONE    = 8'h01;
   localparam logic [7:0] STATUS_PEND    = 8'h00;

   typedef struct packed {
      logic       sel_n;     // chip select, active low
      logic       read;      // high: read, low: write
      logic       chan;      // channel select address bit
      logic [2:0] reg_sel;   // register select address bits
      logic [7:0] wdata;     // data bus value from the host
   } hpi_req_type;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_READ  = 3'b010,
      ST_WRITE = 3'b100
   } hpi_state_type;
endpackage

/* File: test/hpi_cpu_model.sv */
// Purpose: host cpu model that drives the parallel port pins
// Assumes: bus changes 1 ns after the rising edge
// Notes:   no pull on the data bus, so a released bus shows the inverse
`timescale 1ns/1ps
module hpi_cpu_model (
   input  wire logic                  clk_i,
   input  wire logic [7:0]            data_o_i,
   input  wire logic                  data_oe_i,
   output hpi_pkg::hpi_req_type       req_o,
   output logic      [7:0]            bus_o
);
   logic drv = 1'b0;
   initial req_o = '{1'b1, 1'b0, 1'b0, 3'h0, 8'h00};
   // wire level: device wins when enabled, idle bus never holds old data
   always_comb bus_o = data_oe_i ? data_o_i : (drv ? req_o.wdata : ~req_o.wdata);
   // write: held for the taking edge, then chip select released
   task automatic wr(input logic ch, input logic [2:0] rs, input logic [7:0] d);
      @(posedge clk_i) #1;
      req_o = '{1'b0, 1'b0, ch, rs, d};
      drv = 1'b1;
      @(posedge clk_i) #1;
      req_o.sel_n = 1'b1;
      drv = 1'b0;
   endtask
   // write held over extra edges with new data; only the first edge may land
   task automatic wr_hold(input logic ch, input logic [2:0] rs, input logic [7:0] d,
                          input logic [7:0] d2);
      @(posedge clk_i) #1;
      req_o = '{1'b0, 1'b0, ch, rs, d};
      drv = 1'b1;
      @(posedge clk_i) #1;
      req_o.wdata = d2;
      repeat (2) @(posedge clk_i);
      #1 req_o.sel_n = 1'b1;
      drv = 1'b0;
   endtask
   // read: bounded wait for the answer; ok flags the documented latency
   task automatic rd(input logic ch, input logic [2:0] rs, output logic [7:0] d,
                     output logic ok);
      int n;
      n = 0;
      @(posedge clk_i) #1;
      req_o = '{1'b0, 1'b1, ch, rs, req_o.wdata};
      while (data_oe_i !== 1'b1 && n < 6) begin
         @(posedge clk_i) #1;
         n++;
      end
      d = bus_o;
      req_o.sel_n = 1'b1;
      @(posedge clk_i) #1;
      ok = (n == 2) && (data_oe_i === 1'b0);
   endtask
endmodule // hpi_cpu_model

/* File: test/testbench.sv */
// Purpose: self-checking bench for the host port
// Assumes: cpu model owns the bus pins, bench owns sources and reset
// Notes:   rows are {channel, register, data}
`timescale 1ns/1ps
module testbench;
   logic                 clk = 1'b0;
   logic                 rst_n = 1'b0;
   logic [3:0]           src_a = 4'h0, src_b = 4'h0;
   logic [7:0]           dout, bus, rv;
   logic                 oe, irq_n, irq_oe, irq_wire, ok;
   hpi_pkg::hpi_req_type req;
   int                   num_errors = 0, samples_checked = 0;
   logic [11:0]          rows [6] = '{12'h0A5, 12'h75A, 12'hBFF, 12'h83C, 12'h401, 12'hF80};
   always #5 clk = ~clk;
   // pull-up on the shared interrupt line
   assign irq_wire = irq_oe ? irq_n : 1'b1;
   hpi_host_port #(.NUM_SRC(4)) u_dut (.CLK_SYS_I(clk), .RESETN_I(rst_n),
      .CS_N_I(req.sel_n), .READ_I(req.read), .CHAN_SEL_I(req.chan),
      .REG_SEL_I(req.reg_sel), .DATA_I(bus), .SRC_A_I(src_a), .SRC_B_I(src_b),
      .DATA_O(dout), .DATA_OE_O(oe), .IRQ_N_O(irq_n), .IRQ_OE_O(irq_oe));
   hpi_cpu_model u_cpu (.clk_i(clk), .data_o_i(dout), .data_oe_i(oe), .req_o(req),
      .bus_o(bus));
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
      samples_checked++;
      if (s !== e) begin
         $display("mismatch %s expected %h seen %h", nm, e, s);
         num_errors++;
      end
   endtask
   task automatic rdc(input logic ch, input logic [2:0] rs, input logic [7:0] e);
      u_cpu.rd(ch, rs, rv, ok);
      chk("rdata", e, rv);
      chk("latency", 8'h01, {7'h0, ok});
   endtask
   task automatic irqc(input logic [7:0] e);
      repeat (2) @(posedge clk);
      #1 chk("irq", e, {7'h0, irq_wire});
   endtask
   task automatic wrap_up;
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // watchdog sized well past the hundred or so cycles the tests need
   initial begin
      #50000;
      num_errors++;
      wrap_up();
   end
   // table pass, interrupt merging, then a reset in mid-run
   initial begin
      repeat (12) @(posedge clk);
      #1 rst_n = 1'b1;
      chk("oe", 8'h00, {7'h0, oe});
      chk("irq", 8'h01, {7'h0, irq_wire});
      foreach (rows[i]) u_cpu.wr(rows[i][11], rows[i][10:8], rows[i][7:0]);
      foreach (rows[i]) rdc(rows[i][11], rows[i][10:8], rows[i][7:0]);
      u_cpu.wr(1'b0, 3'h1, 8'h0F);
      src_b = 4'hF;
      irqc(8'h01);
      rdc(1'b1, 3'h2, 8'h01);
      src_a = 4'h1;
      irqc(8'h00);
      rdc(1'b0, 3'h2, 8'h00);
      u_cpu.wr(1'b1, 3'h1, 8'h02);
      src_a = 4'h0;
      irqc(8'h00);
      rdc(1'b1, 3'h2, 8'h00);
      src_b = 4'h0;
      irqc(8'h01);
      u_cpu.wr_hold(1'b0, 3'h5, 8'h33, 8'hCC);
      rdc(1'b0, 3'h5, 8'h33);
      rdc(1'b1, 3'h5, 8'h00);
      src_b = 4'h2;
      irqc(8'h00);
      rst_n = 1'b0;
      #1 chk("oe", 8'h00, {7'h0, oe});
      chk("irq", 8'h01, {7'h0, irq_wire});
      repeat (2) @(posedge clk);
      #1 rst_n = 1'b1;
      irqc(8'h01);
      rdc(1'b0, 3'h0, 8'h00);
      rdc(1'b1, 3'h1, 8'h00);
      wrap_up();
   end
endmodule // testbench
